// ==== shared/btl_pkg.sv ====
// package for the basic trigger and key lockout controller
package btl_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned TICK_MS      = 1;
    // cycles per 1 ms timer tick
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    localparam logic [14:0] TICK_LAST    = 15'(TICK_CYCLES - 1);

    // ****************************************************************
    // interval limits in ms ticks
    // ****************************************************************
    localparam logic [26:0] IVAL_MIN     = 27'h0000001;   // 0.001 s
    localparam logic [26:0] IVAL_MAX     = 27'h5F5E0FF;   // 99999.999 s
    localparam logic [26:0] IVAL_RESET   = 27'h0000064;   // 0.1 s

    // ****************************************************************
    // enumerations and carriers
    // ****************************************************************
    typedef enum logic [2:0]
    {
        SRC_FREE,
        SRC_KEY,
        SRC_IFACE,
        SRC_REAR,
        SRC_IVAL
    } btl_src_type;

    typedef enum logic
    {
        MODE_REPEAT,
        MODE_SINGLE
    } btl_mode_type;

    typedef enum logic
    {
        FRONT_TRIGGER_KEY_ADVANCED,
        FRONT_TRIGGER_KEY_BASIC
    } btl_front_trigger_key_type;

    // one decoded host command, each strobe a one-cycle pulse
    typedef struct packed
    {
        logic         serial_port;   // command came in over the serial port
        logic         enter_remote;
        logic         go_local;
        logic         set_lockout;
        logic         lockout_val;
        logic         select_basic;
        logic         select_adv;
        logic         set_mode;
        btl_mode_type mode_val;
        logic         set_src;
        btl_src_type  src_val;
        logic         set_ival;
        logic [26:0]  ival_val;       // interval in ms ticks
        logic         bus_trigger;    // *TRG or GET
    } btl_cmd_type;

    // interlock cable sense
    typedef struct packed
    {
        logic cable_at_unit;
        logic cable_at_fixture;
        logic lid_closed;
    } btl_ilk_type;

    localparam logic [1:0] ARMED_RESET = 2'h0;

endpackage

// ==== hdl/btl_ctrl.sv ====
// basic trigger, front key lockout and interlock reporting controller
// ********************************************************************
// Overview of operation
// [RQ1] lockout on and remote: keys dead
// [RQ2] lockout off: keys live in remote
// [RQ3] lockout command taken only while remote
// [RQ4] leaving remote frees keys, keeps setting
// [RQ5] lockout command only via serial port
// [RQ6] select-basic leaves advanced triggering
// [RQ7] select-basic while basic changes nothing
// [RQ8] repeating mode: after event, trigger continuously
// [RQ9] single mode: one reading per event; code holds at most one waiting event and drops others meanwhile
// [RQ10] free source: readings continuous at once
// [RQ11] trigger key honoured only in local
// [RQ12] bus trigger command counts as event
// [RQ13] rear input pulse is an event
// [RQ14] interval source: reading per expiry
// [RQ15] interval 1 ms to 99999999 ms, default 100
// [RQ16] interlock reports 1 closed/absent, 0 open
// [RQ17] cable absent: lid and switches unknown
// [RQ18] enter remote via serial, lock if enabled
// [RQ19] interval timer counts whole milliseconds
// ********************************************************************
module btl_ctrl
    import btl_pkg::*;
(
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_b,
    // host command decoder
    input  wire btl_cmd_type  i_cmd,
    // front panel and rear pins
    input  wire logic         i_key_front_trigger_key,      // front_trigger_key, async
    input  wire logic         i_rear_front_trigger_key,     // rear_trigger_input, async
    input  wire btl_ilk_type  i_ilk,           // interlock sense, async
    // measurement engine
    input  wire logic         i_reading_done,  // reading finished
    // status
    output logic              o_remote,
    output logic              o_keys_enabled,
    output logic              o_key_lockout_setting,
    output logic              o_basic_active,
    output logic              o_single_per_event_mode,
    output logic [2:0]        o_src,
    output logic [26:0]       o_ival,
    output logic              o_interlock_ok,
    output logic              o_fixture_known,
    // trigger out
    output logic              o_front_trigger_key
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] key_s_q;
    logic [2:0] rear_s_q;
    logic [2:0] ilk_s0_q;
    logic [2:0] ilk_s1_q;
    logic [2:0] ilk_s2_q;
    logic       key_lvl_q;
    logic       rear_lvl_q;
    logic [2:0] ilk_lvl_q;

    // three stages, a change counts once stages two and three agree
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            key_s_q  <= 3'h0;
            rear_s_q <= 3'h0;
            ilk_s0_q <= 3'h0;
            ilk_s1_q <= 3'h0;
            ilk_s2_q <= 3'h0;
        end
        else
        begin
            key_s_q  <= {key_s_q[1:0], i_key_front_trigger_key};
            rear_s_q <= {rear_s_q[1:0], i_rear_front_trigger_key};
            ilk_s0_q <= i_ilk;
            ilk_s1_q <= ilk_s0_q;
            ilk_s2_q <= ilk_s1_q;
        end
    end

    wire       key_agree  = key_s_q[1] == key_s_q[2];
    wire       rear_agree = rear_s_q[1] == rear_s_q[2];
    wire [2:0] ilk_agree  = ~(ilk_s1_q ^ ilk_s2_q);

    // filtered levels; edges are taken from these, not the first stage
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            key_lvl_q  <= 1'b0;
            rear_lvl_q <= 1'b0;
            ilk_lvl_q  <= 3'h0;
        end
        else
        begin
            key_lvl_q  <= key_agree ? key_s_q[2] : key_lvl_q;
            rear_lvl_q <= rear_agree ? rear_s_q[2] : rear_lvl_q;
            ilk_lvl_q <= (ilk_agree & ilk_s2_q) | (~ilk_agree & ilk_lvl_q);
        end
    end

    logic key_prev_q;
    logic rear_prev_q;
    wire  key_press  = key_lvl_q & ~key_prev_q;
    wire  rear_pulse = rear_lvl_q & ~rear_prev_q;

    // ****************************************************************
    // remote state and key lockout
    // ****************************************************************
    logic remote_q;
    logic lockout_q;
    wire  ser = i_cmd.serial_port;                    // RQ5
    wire  lock_take = i_cmd.set_lockout & ser & remote_q;   // RQ3 RQ5
    wire  remote_d  = (i_cmd.enter_remote & ser) ? 1'b1 :    // RQ18
                      (i_cmd.go_local & ser)     ? 1'b0 :     // RQ4
                      remote_q;
    wire  lockout_d = lock_take ? i_cmd.lockout_val : lockout_q;
    // keys die only with both remote and lockout
    wire  keys_d    = ~(remote_d & lockout_d);                // RQ1 RQ2 RQ4

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            remote_q  <= 1'b0;
            lockout_q <= 1'b0;
        end
        else
        begin
            remote_q  <= remote_d;
            lockout_q <= lockout_d;                          // RQ4
        end
    end

    // ****************************************************************
    // trigger configuration
    // ****************************************************************
    btl_front_trigger_key_type front_trigger_key_q;
    btl_mode_type mode_q;
    btl_src_type  src_q;
    logic [26:0]  ival_q;

    // out-of-range interval is refused and the old one kept
    wire ival_ok = (i_cmd.ival_val >= IVAL_MIN) && (i_cmd.ival_val <= IVAL_MAX); // RQ15
    wire cfg_chg = (i_cmd.set_mode && i_cmd.mode_val != mode_q) ||
                   (i_cmd.set_src && i_cmd.src_val != src_q) ||
                   (i_cmd.set_ival && ival_ok && i_cmd.ival_val != ival_q);
    // entering basic restarts the trigger machine; re-select does nothing
    wire enter_basic = i_cmd.select_basic && front_trigger_key_q != FRONT_TRIGGER_KEY_BASIC; // RQ6 RQ7

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            front_trigger_key_q <= FRONT_TRIGGER_KEY_BASIC;
            mode_q <= MODE_REPEAT;
            src_q  <= SRC_FREE;
            ival_q <= IVAL_RESET;                            // RQ15
        end
        else
        begin
            if (enter_basic)
                front_trigger_key_q <= FRONT_TRIGGER_KEY_BASIC;                        // RQ6
            else if (i_cmd.select_adv)
                front_trigger_key_q <= FRONT_TRIGGER_KEY_ADVANCED;
            mode_q <= i_cmd.set_mode ? i_cmd.mode_val : mode_q;
            src_q  <= i_cmd.set_src ? i_cmd.src_val : src_q;
            ival_q <= (i_cmd.set_ival && ival_ok) ? i_cmd.ival_val : ival_q; // RQ15
        end
    end

    // ****************************************************************
    // millisecond tick and interval timer
    // ****************************************************************
    logic [14:0] tick_cnt_q;
    logic [26:0] ival_cnt_q;
    wire         tick     = tick_cnt_q == TICK_LAST;          // RQ19
    wire         ival_run = front_trigger_key_q == FRONT_TRIGGER_KEY_BASIC && src_q == SRC_IVAL;
    wire         ival_exp = ival_run && tick && ival_cnt_q >= ival_q - 27'h1; // RQ14

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tick_cnt_q <= 15'h0;
            ival_cnt_q <= 27'h0;
        end
        else
        begin
            tick_cnt_q <= tick ? 15'h0 : tick_cnt_q + 15'h1;
            if (!ival_run || cfg_chg || ival_exp)
                ival_cnt_q <= 27'h0;
            else if (tick)
                ival_cnt_q <= ival_cnt_q + 27'h1;            // RQ19
        end
    end

    // ****************************************************************
    // event selection and trigger generation
    // ****************************************************************
    logic event_w;
    always_comb
    begin
        unique case (src_q)
            SRC_FREE:  event_w = 1'b1;                       // RQ10
            SRC_KEY:   event_w = key_press & ~remote_q;      // RQ11
            SRC_IFACE: event_w = i_cmd.bus_trigger;          // RQ12
            SRC_REAR:  event_w = rear_pulse;                 // RQ13
            SRC_IVAL:  event_w = ival_exp;                   // RQ14
            default:   event_w = 1'b0;
        endcase
    end

    // armed: repeating mode has seen its event; pend: single event waiting
    logic armed_q;
    logic pend_q;
    logic busy_q;
    wire  basic   = front_trigger_key_q == FRONT_TRIGGER_KEY_BASIC;
    wire  repeat_go = basic && mode_q == MODE_REPEAT && (armed_q || event_w); // RQ8
    wire  single_go = basic && mode_q == MODE_SINGLE && (pend_q || event_w);  // RQ9
    wire  fire    = !busy_q && (repeat_go || single_go);

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            key_prev_q  <= 1'b0;
            rear_prev_q <= 1'b0;
            armed_q     <= 1'b0;
            pend_q      <= 1'b0;
            busy_q      <= 1'b0;
        end
        else
        begin
            key_prev_q  <= key_lvl_q;
            rear_prev_q <= rear_lvl_q;
            if (!basic || enter_basic || cfg_chg)
                armed_q <= 1'b0;
            else if (mode_q == MODE_REPEAT && event_w)
                armed_q <= 1'b1;                             // RQ8
            // event while busy is held, one reading later; one arriving as the held event fires is dropped
            if (!basic || enter_basic || cfg_chg)
                pend_q <= 1'b0;
            else if (mode_q == MODE_SINGLE && event_w && busy_q)
                pend_q <= 1'b1;                              // RQ9
            else if (fire)
                pend_q <= 1'b0;
            busy_q <= fire ? 1'b1 : (i_reading_done ? 1'b0 : busy_q);
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_remote                <= 1'b0;
            o_keys_enabled          <= 1'b1;
            o_key_lockout_setting   <= 1'b0;
            o_basic_active          <= 1'b1;
            o_single_per_event_mode <= 1'b0;
            o_src                   <= 3'h0;
            o_ival                  <= IVAL_RESET;
            o_interlock_ok          <= 1'b1;
            o_fixture_known         <= 1'b0;
            o_front_trigger_key                  <= 1'b0;
        end
        else
        begin
            o_remote                <= remote_d;
            o_keys_enabled          <= keys_d;               // RQ1 RQ2
            o_key_lockout_setting   <= lockout_d;
            o_basic_active          <= front_trigger_key_q == FRONT_TRIGGER_KEY_BASIC;
            o_single_per_event_mode <= mode_q == MODE_SINGLE;
            o_src                   <= src_q;
            o_ival                  <= ival_q;
            // absent cable reads 1; attached needs fixture and closed lid
            o_interlock_ok  <= ~ilk_lvl_q[2] | (ilk_lvl_q[1] & ilk_lvl_q[0]); // RQ16
            o_fixture_known <= ilk_lvl_q[2];                  // RQ17
            o_front_trigger_key          <= fire;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    // keys follow the stored remote and lockout state of the same cycle
    property p_lock;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (remote_q && lockout_q) |-> !o_keys_enabled;
    endproperty
    a_lock: assert property (p_lock) else $error("keys live under lockout"); // RQ1
    property p_local_keys;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!remote_d || !lockout_d) |=> o_keys_enabled;
    endproperty
    a_local_keys: assert property (p_local_keys) else $error("keys dead"); // RQ2
    property p_lock_needs_remote;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!remote_q && i_cmd.set_lockout) |=> $stable(lockout_q);
    endproperty
    a_lock_needs_remote: assert property (p_lock_needs_remote) else $error("lock in local"); // RQ3
    property p_serial_only;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!i_cmd.serial_port) |=> ($stable(lockout_q) && $stable(remote_q));
    endproperty
    a_serial_only: assert property (p_serial_only) else $error("non-serial change"); // RQ5
    // an event in the same cycle may still arm repeat mode
    property p_basic_noop;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_cmd.select_basic && basic && !cfg_chg && !event_w) |=> $stable(armed_q);
    endproperty
    a_basic_noop: assert property (p_basic_noop) else $error("reselect changed state"); // RQ7
    property p_free_run;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (basic && src_q == SRC_FREE && mode_q == MODE_REPEAT && !busy_q)
            |=> o_front_trigger_key;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free source idle"); // RQ10
    property p_key_local;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (src_q == SRC_KEY && remote_q && mode_q == MODE_SINGLE && !pend_q) |=> !o_front_trigger_key;
    endproperty
    a_key_local: assert property (p_key_local) else $error("key honoured in remote"); // RQ11
    property p_ilk;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!ilk_lvl_q[2]) |=> (o_interlock_ok && !o_fixture_known);
    endproperty
    a_ilk: assert property (p_ilk) else $error("absent cable misreported"); // RQ16 RQ17
    property p_ival_range;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        ##1 (ival_q >= IVAL_MIN && ival_q <= IVAL_MAX);
    endproperty
    a_ival_range: assert property (p_ival_range) else $error("interval out of range"); // RQ15

endmodule

// ==== testbench/btl_host_model.sv ====
// remote host model that issues decoded commands to the controller
module btl_host_model
    import btl_pkg::*;
(
    // clock
    input  wire logic   i_ref_clk,
    // command out
    output btl_cmd_type o_cmd
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // command issue
    // ****************************************************************
    initial o_cmd = '0;

    // one-cycle strobe launched just after an edge, fields held with it
    task automatic send(input btl_cmd_type c);
        @(posedge i_ref_clk);
        #1 o_cmd = c;
        @(posedge i_ref_clk);
        #1 o_cmd = '0;
    endtask

    // lockout goes out on the serial port, and only once the unit is remote
    task automatic lockout(input logic v);
        btl_cmd_type c;
        c = '0;
        c.serial_port = 1'b1;
        c.enter_remote = 1'b1;
        send(c);
        c.enter_remote = 1'b0;
        c.set_lockout = 1'b1;
        c.lockout_val = v;
        send(c);
    endtask

    // *TRG and GET both arrive here as the same bus trigger strobe
    task automatic bus_front_trigger_key();
        btl_cmd_type c;
        c = '0;
        c.bus_trigger = 1'b1;
        send(c);
    endtask
endmodule

// ==== testbench/btl_ctrl_test.sv ====
// self-checking bench for the basic trigger and key lockout controller
module btl_ctrl_test;
    import btl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // signals and bench state
    // ****************************************************************
    logic        i_ref_clk, i_rst_b, i_key_front_trigger_key, i_rear_front_trigger_key, i_reading_done;
    btl_cmd_type i_cmd;
    btl_ilk_type i_ilk;
    logic        o_remote, o_keys_enabled, o_key_lockout_setting, o_basic_active;
    logic        o_single_per_event_mode, o_interlock_ok, o_fixture_known, o_front_trigger_key;
    logic [2:0]  o_src;
    logic [26:0] o_ival;
    int          error_cnt, cmp_count, front_trigger_key_cnt, done_dly, n, i;
    int          m_rem, m_lock, m_bas, m_mode, m_src, m_ival;
    int unsigned seed;

    btl_host_model host (.i_ref_clk(i_ref_clk), .o_cmd(i_cmd));

    btl_ctrl dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cmd(i_cmd),
        .i_key_front_trigger_key(i_key_front_trigger_key), .i_rear_front_trigger_key(i_rear_front_trigger_key), .i_ilk(i_ilk),
        .i_reading_done(i_reading_done), .o_remote(o_remote),
        .o_keys_enabled(o_keys_enabled), .o_key_lockout_setting(o_key_lockout_setting),
        .o_basic_active(o_basic_active), .o_single_per_event_mode(o_single_per_event_mode),
        .o_src(o_src), .o_ival(o_ival), .o_interlock_ok(o_interlock_ok),
        .o_fixture_known(o_fixture_known), .o_front_trigger_key(o_front_trigger_key));

    // ****************************************************************
    // clock and measurement engine stand-in
    // ****************************************************************
    initial
    begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    // each reading ends three edges after its trigger pulse
    always @(posedge i_ref_clk)
    begin
        if (o_front_trigger_key === 1'b1)
        begin
            front_trigger_key_cnt++;
            done_dly = 3;
        end
        else if (done_dly > 0)
            done_dly--;
        #1 i_reading_done = (done_dly == 1);
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // status levels except interlock and fixture known against the model
    task automatic st();
        chk(o_remote, m_rem, "remote");
        chk(o_keys_enabled, !(m_rem && m_lock), "keys");
        chk(o_key_lockout_setting, m_lock, "lockout");
        chk(o_basic_active, m_bas, "basic");
        chk(o_single_per_event_mode, m_mode, "mode");
        chk(o_src, m_src, "src");
        chk(o_ival, m_ival, "ival");
    endtask

    // k: 0 remote 1 local 2 lockout 4 basic 5 adv 6 mode 7 src 8 ival
    task automatic cmd(input int k, input int v, input logic ser);
        btl_cmd_type c;
        c = '0;
        c.serial_port = ser;
        c.lockout_val = v[0];
        c.mode_val = btl_mode_type'(v[0]);
        c.src_val = btl_src_type'(v[2:0]);
        c.ival_val = v[26:0];
        c.enter_remote = (k == 0);
        c.go_local = (k == 1);
        c.set_lockout = (k == 2);
        c.select_basic = (k == 4);
        c.select_adv = (k == 5);
        c.set_mode = (k == 6);
        c.set_src = (k == 7);
        c.set_ival = (k == 8);
        // model: remote control only via serial, lockout only while remote
        if (k == 0 && ser) m_rem = 1;
        if (k == 1 && ser) m_rem = 0;
        if (k == 2 && ser && m_rem == 1) m_lock = v;
        if (k == 4) m_bas = 1;
        if (k == 5) m_bas = 0;
        if (k == 6) m_mode = v;
        if (k == 7) m_src = v;
        if (k == 8 && v >= 1 && v <= int'(IVAL_MAX)) m_ival = v;
        host.send(c);
        tick(3);
        st();
    endtask

    // single-per-event mode: count readings for cnt events of source s
    task automatic ev(input int s, input int cnt, input int exp);
        cmd(7, s, 1'b0);
        cmd(6, 1, 1'b0);
        tick(40);
        front_trigger_key_cnt = 0;
        for (int e = 0; e < cnt; e++)
        begin
            if (s == 1) i_key_front_trigger_key = 1'b1;
            if (s == 3) i_rear_front_trigger_key = 1'b1;
            if (s == 2) host.bus_front_trigger_key();
            tick(10);
            i_key_front_trigger_key = 1'b0;
            i_rear_front_trigger_key = 1'b0;
            tick(30);
        end
        chk(front_trigger_key_cnt, exp, "event readings");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        seed = 33329;
        {error_cnt, cmp_count, front_trigger_key_cnt, done_dly} = '0;
        {m_rem, m_lock, m_src, m_mode} = '0;
        m_bas = 1;
        m_ival = int'(IVAL_RESET);
        {i_rst_b, i_key_front_trigger_key, i_rear_front_trigger_key, i_reading_done} = '0;
        i_ilk = 3'h7;
        tick(2);
        i_rst_b = 1'b1;
        tick(4);
        st();
        front_trigger_key_cnt = 0;
        tick(200);
        chk(front_trigger_key_cnt >= 20, 1, "free run");
        $display("test reset and free run done");
        cmd(2, 1, 1'b1);
        cmd(0, 0, 1'b0);
        cmd(0, 0, 1'b1);
        cmd(2, 1, 1'b0);
        cmd(2, 1, 1'b1);
        ev(1, 2, 0);
        cmd(1, 0, 1'b1);
        host.lockout(1'b0);
        m_rem = 1;
        m_lock = 0;
        tick(3);
        st();
        cmd(1, 0, 1'b1);
        $display("test lockout done");
        ev(1, 2, 2);
        n = 1 + rnd() % 4;
        ev(2, n, n);
        n = 1 + rnd() % 4;
        ev(3, n, n);
        // repeating mode stays idle until its first event, then runs on
        cmd(6, 0, 1'b0);
        front_trigger_key_cnt = 0;
        tick(40);
        chk(front_trigger_key_cnt, 0, "repeat idle");
        i_rear_front_trigger_key = 1'b1;
        tick(10);
        i_rear_front_trigger_key = 1'b0;
        tick(100);
        chk(front_trigger_key_cnt >= 15, 1, "repeat run");
        $display("test event sources done");
        cmd(4, 0, 1'b0);
        front_trigger_key_cnt = 0;
        tick(50);
        chk(front_trigger_key_cnt >= 5, 1, "reselect kept run");
        cmd(5, 0, 1'b0);
        front_trigger_key_cnt = 0;
        tick(50);
        chk(front_trigger_key_cnt, 0, "advanced idle");
        cmd(4, 0, 1'b0);
        for (i = 0; i < 8; i++)
        begin
            i_ilk = btl_ilk_type'(3'(rnd() % 8));
            tick(10);
            chk(o_interlock_ok, !i_ilk.cable_at_unit || (i_ilk.cable_at_fixture
                && i_ilk.lid_closed), "interlock");
            chk(o_fixture_known, i_ilk.cable_at_unit, "known");
        end
        $display("test mode select and interlock done");
        cmd(8, 0, 1'b0);
        cmd(8, int'(IVAL_MAX) + 1, 1'b0);
        cmd(8, int'(IVAL_MAX), 1'b0);
        cmd(8, 1, 1'b0);
        cmd(6, 1, 1'b0);
        cmd(7, 4, 1'b0);
        front_trigger_key_cnt = 0;
        tick(70000);
        chk(front_trigger_key_cnt >= 3 && front_trigger_key_cnt <= 4, 1, "interval");
        $display("test interval done");
        end_of_test();
    end
endmodule
